// [src/pcact_pkg.sv]
// package for the counter compare timer: register map, field layout, types
`default_nettype none
package pcact_pkg;
	localparam int NUM_MODULES = 5;
	// byte addresses of the 32-bit register words
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_MODE    = 8'h04;
	localparam logic [7:0] OFS_COUNT   = 8'h08;
	localparam logic [7:0] OFS_IRQSTAT = 8'h0C;
	localparam logic [7:0] OFS_IRQMASK = 8'h10;
	localparam logic [7:0] OFS_MMODE0  = 8'h20;
	localparam logic [7:0] OFS_CMPLO0  = 8'h40;
	localparam logic [7:0] OFS_CMPHI0  = 8'h60;
	localparam logic [7:0] OFS_STRIDE  = 8'h04;
	// control register fields
	localparam int CTRL_OVF_BIT = 7;
	localparam int CTRL_RUN_BIT = 6;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CTRL_WMASK = 8'h40;
	// mode register fields
	localparam int MODE_IDLE_BIT = 7;
	localparam int MODE_WDOG_BIT = 6;
	localparam int MODE_SRC_HI   = 2;
	localparam int MODE_SRC_LO   = 1;
	localparam int MODE_OVFIE_BIT = 0;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] MODE_WMASK = 8'hC7;
	// module mode register fields
	localparam int MM_CMP_BIT   = 6;
	localparam int MM_MATCH_BIT = 3;
	localparam int MM_IRQ_BIT   = 0;
	localparam logic [7:0] MM_WMASK = 8'h7F;
	localparam logic [7:0] MM_RESET = 8'h00;
	localparam logic [7:0] CMP_RESET = 8'h00;
	// interrupt status layout: bit 5 overflow, bits 4..0 module events
	localparam int IRQ_OVF_BIT = 5;
	localparam int IRQ_W = 6;
	// count source prescales
	localparam int DIV12 = 12;
	localparam int DIV4  = 4;
	// shortest legal spacing of external count events
	localparam real EXT_MIN_NS_12MHZ = 660.0;
	typedef enum logic [1:0] {
		PCACT_SRC_DIV12,
		PCACT_SRC_DIV4,
		PCACT_SRC_TMR0,
		PCACT_SRC_EXT
	} pcact_src_t;
	// one decoded bus access
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
	} pcact_acc_t;
endpackage : pcact_pkg
`default_nettype wire

// [src/pcact_tick_gen.sv]
// count-event generator: prescalers, timer overflow and external pin edge
`default_nettype none
module pcact_tick_gen (
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic               run,
	input  wire pcact_pkg::pcact_src_t src,
	input  wire logic               tmr0Overflow,
	input  wire logic               extCount,
	output logic                    tick
);
	logic [3:0] div12_q;
	logic [1:0] div4_q;
	logic       extPrev_q;
	logic       extRise;

	// free-running prescalers so the phase does not depend on the run bit
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div12_q <= 4'h0;
			div4_q  <= 2'h0;
		end else begin
			div12_q <= (div12_q == 4'(pcact_pkg::DIV12 - 1)) ? 4'h0 : div12_q + 4'h1;
			div4_q  <= div4_q + 2'h1;
		end
	end

	// external input is synchronous; count its rising edges
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			extPrev_q <= 1'b0;
		end else begin
			extPrev_q <= extCount;
		end
	end
	assign extRise = extCount & ~extPrev_q;

	// select one-cycle increment pulse
	always_comb begin
		tick = 1'b0;
		if (run) begin
			case (src)
				pcact_pkg::PCACT_SRC_DIV12: tick = (div12_q == 4'(pcact_pkg::DIV12 - 1));
				pcact_pkg::PCACT_SRC_DIV4:  tick = (div4_q == 2'(pcact_pkg::DIV4 - 1));
				pcact_pkg::PCACT_SRC_TMR0:  tick = tmr0Overflow;
				pcact_pkg::PCACT_SRC_EXT:   tick = extRise;
				default:                    tick = 1'b0;
			endcase
		end
	end
endmodule : pcact_tick_gen
`default_nettype wire

// [src/pcact_timer.sv]
// counter compare timer with AHB-Lite register slave and interrupt
//
// Overview of operation
// - mode register source code picks osc/12, osc/4 or timer 0 overflow.
// - mode bit 0 enables overflow interrupt independently of the source.
// - source code 6/7 counts pulses on the external count pin.
// - timer 0 overflows count even without their own interrupt enabled.
// - module is a 16-bit software timer when comparator and match enabled.
// - full 16-bit counter equals compare bytes sets that module's event flag.
// - module interrupt needs both event flag and its interrupt enable.
// - writing the low compare byte disables that module's comparator.
// - software writes low then high; high byte write re-enables comparator.
// - mode register: idle bit7, watchdog bit6, source bits2:1, irq bit0.
// - control: overflow flag bit7, run bit6, reserved bit5, event flags 4..0.
// - module mode bits 6..0: cmp, rise, fall, match, toggle, pwm, irq enable.
//
// Design decisions made here: the address map and the AHB-Lite slave port.
`default_nettype none
module pcact_timer (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        tmr0Overflow,
	input  wire logic        extCount,
	output logic             irq,
	output logic             counterIrq
);
	localparam int N = pcact_pkg::NUM_MODULES;

	pcact_pkg::pcact_acc_t acc_q;
	logic [7:0]  ctrl_q;
	logic [7:0]  mode_q;
	logic [15:0] count_q;
	logic [N-1:0] evFlag_q;
	logic        ovfFlag_q;
	logic [7:0]  mmode_q [N];
	logic [7:0]  cmpLo_q [N];
	logic [7:0]  cmpHi_q [N];
	logic [N-1:0] cmpArmed_q;
	logic [pcact_pkg::IRQ_W-1:0] irqStat_q;
	logic [pcact_pkg::IRQ_W-1:0] irqMask_q;
	logic [N-1:0] match;
	logic        tick;
	logic        wrStrobe;
	logic [7:0]  wByte;
	logic        ovfEvent;
	logic        counterIrq_d;
	logic [31:0] rdata_d;
	pcact_pkg::pcact_src_t src;

	assign src = pcact_pkg::pcact_src_t'(mode_q[pcact_pkg::MODE_SRC_HI:pcact_pkg::MODE_SRC_LO]);
	assign wrStrobe = acc_q.wr;
	assign wByte = hwdata[7:0];

	pcact_tick_gen u_tick (
		.clk          (clk),
		.rst_n        (rst_n),
		.run          (ctrl_q[pcact_pkg::CTRL_RUN_BIT]),
		.src          (src),
		.tmr0Overflow (tmr0Overflow),
		.extCount     (extCount),
		.tick         (tick)
	);

	// address phase capture; the slave never inserts wait states
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_q <= '0;
		end else if (hready) begin
			acc_q.wr   <= hsel & htrans[1] & hwrite;
			acc_q.rd   <= hsel & htrans[1] & ~hwrite;
			acc_q.addr <= haddr[7:0];
		end else begin
			acc_q.wr <= 1'b0;
			acc_q.rd <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// mode and run registers; idle and watchdog bits are storage only here
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= pcact_pkg::MODE_RESET;
			ctrl_q <= pcact_pkg::CTRL_RESET;
		end else if (wrStrobe) begin
			if (acc_q.addr == pcact_pkg::OFS_MODE) begin
				mode_q <= wByte & pcact_pkg::MODE_WMASK;
			end
			if (acc_q.addr == pcact_pkg::OFS_CTRL) begin
				ctrl_q <= wByte & pcact_pkg::CTRL_WMASK;
			end
		end
	end

	// the counter, overflow on roll-over from all ones
	assign ovfEvent = tick & (count_q == 16'hFFFF);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_q <= 16'h0000;
		end else if (wrStrobe && acc_q.addr == pcact_pkg::OFS_COUNT) begin
			count_q <= hwdata[15:0];
		end else if (tick) begin
			count_q <= count_q + 16'h0001;
		end
	end

	// flag in control register: set wins over a software clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ovfFlag_q <= 1'b0;
		end else if (ovfEvent) begin
			ovfFlag_q <= 1'b1;
		end else if (wrStrobe && acc_q.addr == pcact_pkg::OFS_CTRL
				&& !wByte[pcact_pkg::CTRL_OVF_BIT]) begin
			ovfFlag_q <= 1'b0;
		end
	end

	// per-module compare registers, arming and event flags
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_mod
			localparam logic [7:0] OFS = 8'(g * 4);
			// a write to the low byte disarms; the high byte write re-arms
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					mmode_q[g]    <= pcact_pkg::MM_RESET;
					cmpLo_q[g]    <= pcact_pkg::CMP_RESET;
					cmpHi_q[g]    <= pcact_pkg::CMP_RESET;
					cmpArmed_q[g] <= 1'b1;
				end else if (wrStrobe) begin
					if (acc_q.addr == pcact_pkg::OFS_MMODE0 + OFS) begin
						mmode_q[g] <= wByte & pcact_pkg::MM_WMASK;
					end
					if (acc_q.addr == pcact_pkg::OFS_CMPLO0 + OFS) begin
						cmpLo_q[g]    <= wByte;
						cmpArmed_q[g] <= 1'b0;
					end
					if (acc_q.addr == pcact_pkg::OFS_CMPHI0 + OFS) begin
						cmpHi_q[g]    <= wByte;
						cmpArmed_q[g] <= 1'b1;
					end
				end
			end

			// match only on the counting edge, so a count resting on the value fires once and a stopped count never fires
			assign match[g] = mmode_q[g][pcact_pkg::MM_CMP_BIT]
				& mmode_q[g][pcact_pkg::MM_MATCH_BIT] & cmpArmed_q[g]
				& (count_q == {cmpHi_q[g], cmpLo_q[g]}) & tick;

			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					evFlag_q[g] <= 1'b0;
				end else if (match[g]) begin
					evFlag_q[g] <= 1'b1;
				end else if (wrStrobe && acc_q.addr == pcact_pkg::OFS_CTRL && !wByte[g]) begin
					evFlag_q[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// counter-array request: overflow with its enable, or any enabled event
	always_comb begin
		counterIrq_d = ovfFlag_q & mode_q[pcact_pkg::MODE_OVFIE_BIT];
		for (int i = 0; i < N; i++) begin
			counterIrq_d = counterIrq_d | (evFlag_q[i] & mmode_q[i][pcact_pkg::MM_IRQ_BIT]);
		end
	end

	// sticky status for bus interrupt, cleared by writing one; set wins
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irqStat_q <= '0;
			irqMask_q <= '0;
		end else begin
			irqStat_q <= (irqStat_q & ~((wrStrobe && acc_q.addr == pcact_pkg::OFS_IRQSTAT)
				? hwdata[pcact_pkg::IRQ_W-1:0] : '0)) | {ovfEvent, match};
			if (wrStrobe && acc_q.addr == pcact_pkg::OFS_IRQMASK) begin
				irqMask_q <= hwdata[pcact_pkg::IRQ_W-1:0];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq        <= 1'b0;
			counterIrq <= 1'b0;
		end else begin
			irq        <= |(irqStat_q & irqMask_q);
			counterIrq <= counterIrq_d;
		end
	end

	// read mux, unmapped reads return zero
	always_comb begin
		rdata_d = 32'h0000_0000;
		case (haddr[7:0])
			pcact_pkg::OFS_CTRL:    rdata_d[7:0] = {ovfFlag_q, ctrl_q[pcact_pkg::CTRL_RUN_BIT],
				1'b0, evFlag_q};
			pcact_pkg::OFS_MODE:    rdata_d[7:0] = mode_q;
			pcact_pkg::OFS_COUNT:   rdata_d[15:0] = count_q;
			pcact_pkg::OFS_IRQSTAT: rdata_d[pcact_pkg::IRQ_W-1:0] = irqStat_q;
			pcact_pkg::OFS_IRQMASK: rdata_d[pcact_pkg::IRQ_W-1:0] = irqMask_q;
			default: begin
				for (int i = 0; i < N; i++) begin
					if (haddr[7:0] == pcact_pkg::OFS_MMODE0 + 8'(i * 4)) rdata_d[7:0] = mmode_q[i];
					if (haddr[7:0] == pcact_pkg::OFS_CMPLO0 + 8'(i * 4)) rdata_d[7:0] = cmpLo_q[i];
					if (haddr[7:0] == pcact_pkg::OFS_CMPHI0 + 8'(i * 4)) rdata_d[7:0] = cmpHi_q[i];
				end
			end
		endcase
	end

	// read data registered at the address phase, valid in the data phase
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hrdata <= 32'h0000_0000;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			hrdata <= rdata_d;
		end
	end
endmodule : pcact_timer
`default_nettype wire

// [sim/pcact_timer_assertions.sv]
// assertion checker for the counter compare timer bus and interrupt ports
`default_nettype none
module pcact_timer_checker (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        irq,
	input wire logic        counterIrq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// an accepted read address phase at one register word
	sequence rdAcc(logic [7:0] a);
		hsel && htrans[1] && hready && !hwrite && haddr[7:0] == a;
	endsequence
	a_ready_high: assert property (hreadyout) else $error("wait state inserted");
	a_resp_okay: assert property (!hresp) else $error("error response given");
	a_unmapped_zero: assert property (rdAcc(8'h14) |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_ctrl_reserved: assert property (rdAcc(8'h00) |=> hrdata[31:8] == 24'h0 && !hrdata[5])
		else $error("control reserved bits set");
	a_mode_reserved: assert property (rdAcc(8'h04) |=> hrdata[31:8] == 24'h0 && hrdata[5:3] == 3'h0)
		else $error("mode reserved bits set");
	a_mmode_unused: assert property (rdAcc(8'h20) |=> hrdata[31:7] == 25'h0)
		else $error("module mode bit 7 set");
	// read data must not drift between reads, software may sample late
	a_rdata_holds: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
		else $error("read data changed without a read");
	a_reset_quiet: assert property (!$past(rst_n) |-> !irq && !counterIrq)
		else $error("interrupt high after reset");
endmodule : pcact_timer_checker
bind pcact_timer pcact_timer_checker chk_u (.clk(clk), .rst_n(rst_n), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .irq(irq), .counterIrq(counterIrq));
`default_nettype wire

// [sim/pcact_tb.sv]
// self-checking testbench for the counter compare timer
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic        tmr0Overflow = 1'b0;
	logic        extCount = 1'b0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        irq;
	logic        counterIrq;
	logic [31:0] rdData;
	int          failures = 0;
	int          total_checks = 0;
	always #5 clk = ~clk;
	// single slave, so its ready is the bus ready
	pcact_timer dut_u (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(), .tmr0Overflow(tmr0Overflow), .extCount(extCount),
		.irq(irq), .counterIrq(counterIrq));
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	// range check, since free-running prescalers give one tick of slack
	task automatic inRange(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
		total_checks++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			failures++;
			$display("CHECK FAILED at %0t: got %h expected %h to %h", $time, got, lo, hi);
		end
	endtask : inRange
	task automatic busWait();
		do @(posedge clk); while (hreadyout !== 1'b1);
	endtask : busWait
	// one single transfer: address phase, then data phase
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		busWait();
		htrans <= 2'h0;
		hwdata <= d;
		busWait();
		rdData = hrdata;
	endtask : acc
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		acc(1'b1, a, d);
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		acc(1'b0, a, 32'h0);
		cmp(rdData, exp);
	endtask : rdc
	task automatic extPulses(input int n);
		repeat (n) begin
			@(posedge clk);
			extCount <= 1'b1;
			repeat (8) @(posedge clk);
			extCount <= 1'b0;
			repeat (7) @(posedge clk);
		end
		repeat (8) @(posedge clk);
	endtask : extPulses
	task automatic end_of_test();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_of_test
	// watchdog: the sequence needs well under a thousand cycles
	initial begin
		#100us;
		failures++;
		end_of_test();
	end
	// main sequence
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		rdc(8'h00, 32'h0);
		rdc(8'h04, 32'h0);
		rdc(8'h20, 32'h0);
		rdc(8'h14, 32'h0);
		wr(8'h04, 32'hFF);
		rdc(8'h04, 32'hC7);
		wr(8'h20, 32'hFF);
		rdc(8'h20, 32'h7F);
		// park module 0 so stray matches at count zero do not set flags early
		wr(8'h20, 32'h0);
		wr(8'h00, 32'hFF);
		rdc(8'h00, 32'h40);
		// prescaled sources, then a stopped counter must hold
		for (int i = 0; i < 2; i++) begin
			wr(8'h04, {30'h0, i[0], 1'b0});
			wr(8'h08, 32'h0);
			wr(8'h00, 32'h40);
			repeat (120) @(posedge clk);
			wr(8'h00, 32'h0);
			acc(1'b0, 8'h08, 32'h0);
			inRange(rdData, i ? 32'h1D : 32'h9, i ? 32'h20 : 32'hB);
			repeat (20) @(posedge clk);
			rdc(8'h08, rdData);
		end
		// roll-over with overflow interrupt off and on
		wr(8'h10, 32'h20);
		for (int i = 0; i < 2; i++) begin
			wr(8'h04, {30'h0, 1'b1, i[0]});
			wr(8'h08, 32'hFFFF);
			wr(8'h00, 32'h40);
			repeat (12) @(posedge clk);
			wr(8'h00, 32'hC0);
			repeat (2) @(posedge clk);
			cmp({31'h0, counterIrq}, {31'h0, i[0]});
			cmp({31'h0, irq}, 32'h1);
			// run was kept on by the flag-preserving write, so bit 6 reads back
			rdc(8'h00, 32'hC0);
			wr(8'h10, 32'h0);
			repeat (2) @(posedge clk);
			cmp({31'h0, irq}, 32'h0);
			wr(8'h10, 32'h20);
			wr(8'h0C, 32'h20);
			wr(8'h00, 32'h0);
			repeat (2) @(posedge clk);
			cmp({30'h0, irq, counterIrq}, 32'h0);
			rdc(8'h0C, 32'h0);
		end
		// timer 0 overflow pulses as the count source
		wr(8'h04, 32'h04);
		wr(8'h08, 32'h0);
		wr(8'h00, 32'h40);
		repeat (5) begin
			@(posedge clk);
			tmr0Overflow <= 1'b1;
			@(posedge clk);
			tmr0Overflow <= 1'b0;
		end
		repeat (4) @(posedge clk);
		rdc(8'h08, 32'h5);
		// software timer on module 0, counted by external edges
		wr(8'h04, 32'h07);
		wr(8'h08, 32'h0);
		wr(8'h20, 32'h49);
		wr(8'h40, 32'h05);
		wr(8'h60, 32'h0);
		extPulses(5);
		rdc(8'h08, 32'h5);
		rdc(8'h00, 32'h40);
		extPulses(1);
		rdc(8'h00, 32'h41);
		cmp({31'h0, counterIrq}, 32'h1);
		// interrupts held off before the compare value is reloaded
		wr(8'h20, 32'h48);
		repeat (2) @(posedge clk);
		cmp({31'h0, counterIrq}, 32'h0);
		wr(8'h00, 32'h40);
		wr(8'h40, 32'h07);
		extPulses(3);
		rdc(8'h00, 32'h40);
		wr(8'h60, 32'h0);
		wr(8'h08, 32'h7);
		extPulses(1);
		rdc(8'h00, 32'h41);
		end_of_test();
	end
endmodule : tb
`default_nettype wire
